// ==== sbr_pkg.sv ====
// Package for the supply status, interrupt mask/source and transceiver register bank.
// Assumes an internal register access port (address, read/write strobes, byte data) fed by the serial front end.
package sbr_pkg;
    localparam logic [7:0] ADDR_SUPPLY_STATUS = 8'h1B;
    localparam logic [7:0] ADDR_IRQ_ENABLE_A = 8'h1D;
    localparam logic [7:0] ADDR_IRQ_ENABLE_B = 8'h1E;
    localparam logic [7:0] ADDR_IRQ_SOURCE_A = 8'h21;
    localparam logic [7:0] ADDR_IRQ_SOURCE_B = 8'h22;
    localparam logic [7:0] ADDR_XCVR_CTRL = 8'h24;
    localparam logic [7:0] ADDR_MODE_CONTROL = 8'h10;
    localparam logic [7:0] ADDR_MODE_CONTROL_VERIFY = 8'h11;
    localparam int SUP_VB0 = 0;
    localparam int SUP_VB1 = 1;
    localparam int SUP_V2 = 2;
    localparam int SUP_V3 = 3;
    localparam logic [3:0] SUPPLY_POR = 4'h1;
    localparam int XCVR_TOT = 3;
    localparam logic [2:0] XCVR_TERM_BAT = 3'h0;
    localparam logic [2:0] XCVR_RX_ONLY = 3'h2;
    localparam logic [2:0] XCVR_RX_TX = 3'h3;
    localparam logic [2:0] WD_DISABLE_KEY = 3'h3;
    localparam int CLOCK_HZ = 40000000;
    localparam int NR_TIMEOUT_MS = 75;
    localparam int NR_TIMEOUT_CYCLES = NR_TIMEOUT_MS * (CLOCK_HZ / 1000);
    typedef enum logic [1:0] {
        SBR_NORMAL_REQ = 2'b00,
        SBR_NORMAL = 2'b01,
        SBR_STANDBY = 2'b11,
        SBR_SLEEP = 2'b10
    } sbr_mode_t;
endpackage : sbr_pkg

// ==== sbr_flag_if.sv ====
// Interface carrying raw status conditions from the top to the latch module.
// Assumes all members are synchronous to clock.
`timescale 1ns/1ps
interface sbr_flag_if;
    logic [6:0] raw;
    logic [6:0] clr;
    logic [6:0] held;
    modport src (output raw, output clr, input held);
    modport latch (input raw, input clr, output held);
endinterface : sbr_flag_if

// ==== sbr_sync3.sv ====
// Three-stage synchroniser with agreement filter for asynchronous pins.
// Assumes the input may change at any time relative to clock.
`timescale 1ns/1ps
module sbr_sync3 #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] s1_r, s2_r, s3_r, q_r, q_nxt;
    always_comb begin
        q_nxt = q_r;
        for (int i = 0; i < W; i++) begin
            if (s2_r[i] == s3_r[i]) begin
                q_nxt[i] = s3_r[i];
            end
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q_r <= '0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q_r <= q_nxt;
        end
    end
    assign dout = q_r;
endmodule : sbr_sync3

// ==== sbr_regs.sv ====
// Supply status, interrupt mask/source and transceiver register bank.
// Assumes a byte-wide register port from the serial front end on the same clock; raw conditions from pins.
`timescale 1ns/1ps
module sbr_regs #(
    parameter int NR_TIMEOUT = sbr_pkg::NR_TIMEOUT_CYCLES
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reset_line_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic trigger_word,
    input wire logic [1:0] trigger_mode,
    input wire logic second_regulator_on,
    input wire logic battery_switch_overtemp,
    input wire logic battery_low_condition,
    input wire logic battery_high_condition,
    input wire logic high_temp,
    input wire logic temp_prewarn,
    input wire logic bus_fault,
    input wire logic serial_error,
    input wire logic wake_event,
    input wire logic xcvr_overtemp,
    input wire logic xcvr_forced_term,
    output logic irq_n,
    output logic [2:0] xcvr_state,
    output logic [1:0] chip_mode,
    output logic watchdog_enabled,
    output logic first_regulator_on,
    output logic second_regulator_allowed
);
    import sbr_pkg::*;

    logic [10:0] pins_raw, pins;
    sbr_flag_if fl ();

    assign pins_raw = {xcvr_forced_term, xcvr_overtemp, wake_event, serial_error, bus_fault,
                       temp_prewarn, high_temp, battery_high_condition, battery_low_condition,
                       battery_switch_overtemp, second_regulator_on};
    sbr_sync3 #(.W(11)) u_sync (
        .clock(clock),
        .rst_n(rst_n),
        .din(pins_raw),
        .dout(pins)
    );

    logic rd_sup, rd_x, wr_x, wr_a, wr_b, wr_mc, wr_mcv;
    always_comb begin
        rd_sup = reg_rd && (reg_addr == ADDR_SUPPLY_STATUS);
        rd_x = reg_rd && (reg_addr == ADDR_XCVR_CTRL);
        wr_x = reg_wr && (reg_addr == ADDR_XCVR_CTRL);
        wr_a = reg_wr && (reg_addr == ADDR_IRQ_ENABLE_A);
        wr_b = reg_wr && (reg_addr == ADDR_IRQ_ENABLE_B);
        wr_mc = reg_wr && (reg_addr == ADDR_MODE_CONTROL);
        wr_mcv = reg_wr && (reg_addr == ADDR_MODE_CONTROL_VERIFY);
    end

    // Latched flags: 0 second regulator, 1 switch overtemp, 2 battery low, 3 xcvr overtemp
    assign fl.raw = {3'h0, pins[9], pins[2], pins[1], pins[0]};
    assign fl.clr = {3'h0, rd_x, rd_sup, rd_sup, rd_sup};
    sbr_latch #(.W(7)) u_latch (
        .clock(clock),
        .rst_n(rst_n),
        .reset_line_n(reset_line_n),
        .fl(fl.latch)
    );

    // Latched flags hold until their own register is read, bits 0 and 1 also until the reset line; set still wins over that read
    AST_SUP_LATCH_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
        (fl.held[2] && !rd_sup) |=> fl.held[2])
        else $error("battery low flag lost before read");
    AST_SUP_CLEAR_ON_READ: assert property (@(posedge clock) disable iff (!rst_n)
        (rd_sup && pins[2:0] == 3'h0) |=> fl.held[2:0] == 3'h0)
        else $error("supply flags not cleared by read");
    AST_XCVR_OT_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
        (fl.held[3] && !rd_x) |=> fl.held[3])
        else $error("transceiver overtemp flag lost before read");
    AST_XCVR_OT_CLEAR: assert property (@(posedge clock) disable iff (!rst_n)
        (rd_x && !pins[9]) |=> !fl.held[3])
        else $error("transceiver overtemp flag not cleared by read");

    logic [3:0] sup_view;
    always_comb begin
        sup_view = '0;
        sup_view[SUP_V2] = fl.held[0];
        sup_view[SUP_V3] = fl.held[1];
        sup_view[SUP_VB0] = fl.held[2];
        sup_view[SUP_VB1] = pins[3];
    end

    // Mask registers cleared by power-on and reset line
    logic [3:0] en_a_r, en_a_nxt;
    logic [2:0] en_b_r, en_b_nxt;
    always_comb begin
        en_a_nxt = en_a_r;
        en_b_nxt = en_b_r;
        if (!reset_line_n) begin
            en_a_nxt = '0;
            en_b_nxt = '0;
        end else begin
            if (wr_a) en_a_nxt = reg_wdata[3:0];
            if (wr_b) en_b_nxt = reg_wdata[2:0];
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            en_a_r <= '0;
            en_b_r <= '0;
        end else begin
            en_a_r <= en_a_nxt;
            en_b_r <= en_b_nxt;
        end
    end

    // Source mirrors: no storage but A bit 0 (latched battery low, cleared by a supply status read); their own access cannot clear them
    logic [3:0] src_a;
    logic [2:0] src_b;
    always_comb begin
        src_a = {pins[3], pins[4], pins[5], fl.held[2]};
        src_b = {pins[6], pins[7], pins[8]};
    end

    // Chip mode and watchdog
    sbr_mode_t mode_r, mode_nxt;
    logic [31:0] nr_cnt_r, nr_cnt_nxt;
    logic wd_en_r, wd_en_nxt, key_armed_r, key_armed_nxt;
    always_comb begin
        mode_nxt = mode_r;
        nr_cnt_nxt = nr_cnt_r;
        wd_en_nxt = wd_en_r;
        key_armed_nxt = key_armed_r;
        unique case (mode_r)
            SBR_NORMAL_REQ: begin
                if (trigger_word) begin
                    mode_nxt = SBR_NORMAL;
                    nr_cnt_nxt = '0;
                end else if (nr_cnt_r >= 32'(NR_TIMEOUT - 1)) begin
                    mode_nxt = SBR_SLEEP;
                end else begin
                    nr_cnt_nxt = nr_cnt_r + 32'h1;
                end
            end
            SBR_NORMAL, SBR_STANDBY: begin
                if (trigger_word) begin
                    mode_nxt = sbr_mode_t'(trigger_mode);
                end
            end
            SBR_SLEEP: begin
                mode_nxt = SBR_SLEEP;
            end
        endcase
        if (wr_mc) begin
            key_armed_nxt = (reg_wdata[2:0] == WD_DISABLE_KEY) && (mode_r == SBR_STANDBY);
        end else if (wr_mcv) begin
            key_armed_nxt = 1'b0;
            if (key_armed_r && reg_wdata[2:0] == WD_DISABLE_KEY && mode_r == SBR_STANDBY) begin
                wd_en_nxt = 1'b0;
            end
        end
        if (!wd_en_r) begin
            mode_nxt = SBR_STANDBY;
        end
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= SBR_NORMAL_REQ;
            nr_cnt_r <= '0;
            wd_en_r <= 1'b1;
            key_armed_r <= 1'b0;
        end else begin
            mode_r <= mode_nxt;
            nr_cnt_r <= nr_cnt_nxt;
            wd_en_r <= wd_en_nxt;
            key_armed_r <= key_armed_nxt;
        end
    end

    // Transceiver control; the reset line does not touch it
    logic [2:0] xsel_r, xsel_nxt, xstate;
    logic force_term;
    always_comb begin
        force_term = pins[10] || !wd_en_r || (mode_r == SBR_SLEEP);
        xsel_nxt = xsel_r;
        if (wr_x) xsel_nxt = reg_wdata[2:0];
        if (force_term) xsel_nxt[1:0] = 2'h0;
        xstate = force_term ? XCVR_TERM_BAT : xsel_r;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            xsel_r <= '0;
        end else begin
            xsel_r <= xsel_nxt;
        end
    end

    // Outputs all registered
    logic [7:0] rdata_nxt;
    logic irq_n_nxt;
    always_comb begin
        rdata_nxt = reg_rdata;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_SUPPLY_STATUS: rdata_nxt = {4'h0, sup_view};
                ADDR_IRQ_ENABLE_A: rdata_nxt = {4'h0, en_a_r};
                ADDR_IRQ_ENABLE_B: rdata_nxt = {5'h00, en_b_r};
                ADDR_IRQ_SOURCE_A: rdata_nxt = {4'h0, src_a};
                ADDR_IRQ_SOURCE_B: rdata_nxt = {5'h00, src_b};
                ADDR_XCVR_CTRL: rdata_nxt = {4'h0, fl.held[3], xstate};
                default: rdata_nxt = 8'h00;
            endcase
        end
        irq_n_nxt = !(|(src_a & en_a_r) || |(src_b & en_b_r));
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= '0;
            irq_n <= 1'b1;
            xcvr_state <= '0;
            chip_mode <= SBR_NORMAL_REQ;
            watchdog_enabled <= 1'b1;
            first_regulator_on <= 1'b1;
            second_regulator_allowed <= 1'b1;
        end else begin
            reg_rdata <= rdata_nxt;
            irq_n <= irq_n_nxt;
            xcvr_state <= xstate;
            chip_mode <= mode_r;
            watchdog_enabled <= wd_en_r;
            first_regulator_on <= (mode_r != SBR_SLEEP);
            second_regulator_allowed <= wd_en_r && (mode_r != SBR_SLEEP);
        end
    end

    AST_IRQ_MASKED: assert property (@(posedge clock) disable iff (!rst_n)
        (en_a_r == 4'h0 && en_b_r == 3'h0) |=> irq_n)
        else $error("interrupt raised with all masks clear");
    AST_MASK_RESET_LINE: assert property (@(posedge clock) disable iff (!rst_n)
        !reset_line_n |=> (en_a_r == 4'h0 && en_b_r == 3'h0))
        else $error("masks not cleared by reset line");
    AST_MASK_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_a && reset_line_n) |=> en_a_r == $past(reg_wdata[3:0]))
        else $error("mask A write lost");
    // Only a pin change may move the copy; the battery-low bit is held out while it can still set
    AST_SRC_STABLE: assert property (@(posedge clock) disable iff (!rst_n)
        (reg_rd && reg_addr == ADDR_IRQ_SOURCE_A && !pins[2]) |=> (!$stable(pins[5:3]) || $stable(src_a)))
        else $error("source read changed contents");
    AST_XCVR_TERM: assert property (@(posedge clock) disable iff (!rst_n)
        force_term |=> xsel_r[1:0] == 2'h0)
        else $error("forced termination kept control bits");
    AST_XCVR_STATE: assert property (@(posedge clock) disable iff (!rst_n)
        force_term |=> xcvr_state == XCVR_TERM_BAT)
        else $error("transceiver not terminated when forced");
    AST_WD_STANDBY_ONLY: assert property (@(posedge clock) disable iff (!rst_n)
        (wd_en_r && mode_r != SBR_STANDBY) |=> wd_en_r)
        else $error("watchdog disabled outside stand-by");
    AST_NO_WD_STANDBY: assert property (@(posedge clock) disable iff (!rst_n)
        !wd_en_r |=> ##1 (mode_r == SBR_STANDBY && !second_regulator_allowed))
        else $error("disabled watchdog left stand-by");
    AST_NR_TIMEOUT: assert property (@(posedge clock) disable iff (!rst_n)
        (mode_r == SBR_NORMAL_REQ && nr_cnt_r >= 32'(NR_TIMEOUT - 1) && !trigger_word)
        |=> mode_r == SBR_SLEEP ##1 !first_regulator_on)
        else $error("normal request timeout not taken");
    AST_SUP_READ: assert property (@(posedge clock) disable iff (!rst_n)
        (rd_sup && !pins[3]) |=> reg_rdata[3:0] == $past(sup_view))
        else $error("supply status read wrong");

    // Register view, mask, interrupt, transceiver and mode checks; the view checks compare against the synchronised pins
    AST_SUP_VB1_LIVE: assert property (@(posedge clock) disable iff (!rst_n)
        rd_sup |=> reg_rdata[SUP_VB1] == $past(pins[3]))
        else $error("over-voltage bit not live");
    AST_MASK_B_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_b && reset_line_n) |=> en_b_r == $past(reg_wdata[2:0]))
        else $error("mask B write lost");
    AST_IRQ_ACTIVE: assert property (@(posedge clock) disable iff (!rst_n)
        (((src_a & en_a_r) != 4'h0) || ((src_b & en_b_r) != 3'h0)) |=> !irq_n)
        else $error("enabled source gave no interrupt");
    AST_SRC_B_COPY: assert property (@(posedge clock) disable iff (!rst_n)
        (reg_rd && reg_addr == ADDR_IRQ_SOURCE_B)
        |=> reg_rdata == {5'h00, $past(pins[6]), $past(pins[7]), $past(pins[8])})
        else $error("source B copy wrong");
    AST_XCVR_WRITE: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_x && !force_term) |=> xsel_r == $past(reg_wdata[2:0]))
        else $error("transceiver control write lost");
    AST_XCVR_KEEP: assert property (@(posedge clock) disable iff (!rst_n)
        (!reset_line_n && !wr_x && !force_term) |=> $stable(xsel_r))
        else $error("transceiver control moved under reset line");
    AST_SLEEP_TERM: assert property (@(posedge clock) disable iff (!rst_n)
        (mode_r == SBR_SLEEP) |=> xcvr_state == XCVR_TERM_BAT)
        else $error("transceiver active in sleep");
    AST_WD_DISABLE: assert property (@(posedge clock) disable iff (!rst_n)
        (wr_mcv && key_armed_r && reg_wdata[2:0] == WD_DISABLE_KEY && mode_r == SBR_STANDBY)
        |=> !wd_en_r)
        else $error("watchdog disable sequence ignored");
    AST_NR_TRIGGER: assert property (@(posedge clock) disable iff (!rst_n)
        (mode_r == SBR_NORMAL_REQ && trigger_word && wd_en_r) |=> mode_r == SBR_NORMAL)
        else $error("trigger word did not select normal mode");
    AST_REG1_ON: assert property (@(posedge clock) disable iff (!rst_n)
        (mode_r != SBR_SLEEP) |=> first_regulator_on)
        else $error("regulator one off outside sleep");
endmodule : sbr_regs

// ==== sbr_latch.sv ====
// Sticky flag bank: raw set wins over clear; power-on sets the battery-low flag.
// Assumes raw and clear are on clock; reset line clears bits 0 and 1 only.
`timescale 1ns/1ps
module sbr_latch #(
    parameter int W = 7
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic reset_line_n,
    sbr_flag_if.latch fl
);
    import sbr_pkg::*;
    logic [W-1:0] q_r, q_nxt;
    always_comb begin
        q_nxt = q_r;
        for (int i = 0; i < W; i++) begin
            if (fl.clr[i]) q_nxt[i] = 1'b0;
            if (fl.raw[i]) q_nxt[i] = 1'b1;
        end
        // Reset line clears second-regulator and switch-overtemp status only
        if (!reset_line_n) q_nxt[1:0] = 2'h0;
    end
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q_r <= W'(3'h4);
        end else begin
            q_r <= q_nxt;
        end
    end
    assign fl.held = q_r;
endmodule : sbr_latch

// ==== sbr_host.sv ====
// Host model: drives the byte-wide register port of the register bank like the microcontroller.
// Assumes the bench calls its tasks and that all changes happen at the falling clock edge.
`timescale 1ns/1ps
module sbr_host (
    input wire logic clock,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    import sbr_pkg::*;

    initial begin
        reg_addr = 8'hFF;
        reg_wdata = 8'hFF;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    // Idle bus shows the inverse of the last value so stale data never looks valid
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask : wr

    // Read data is taken one extra cycle later; it stands until the next read anyway
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        reg_addr = ~a;
        @(negedge clock);
        d = reg_rdata;
    endtask : rd

    task automatic wd_disable();
        wr(ADDR_MODE_CONTROL, {5'h00, WD_DISABLE_KEY});
        wr(ADDR_MODE_CONTROL_VERIFY, {5'h00, WD_DISABLE_KEY});
    endtask : wd_disable
endmodule : sbr_host

// ==== sbr_regs_bench.sv ====
// Self-checking bench for the supply status, interrupt and transceiver register bank.
// Assumes the host model drives the register port; status pins are driven here at the falling edge.
`timescale 1ns/1ps
module sbr_regs_bench;
    import sbr_pkg::*;
    // Short normal-request timeout keeps the run brief
    localparam int NR_T = 50;
    logic clock, rst_n, reset_line_n, trigger_word, reg_wr, reg_rd;
    logic [1:0] trigger_mode, mode;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic v2_on, sw_ot, bat_low, bat_high, xcvr_ot, xcvr_term;
    logic [5:0] src;
    logic irq_n, wd_en, reg1_on, reg2_ok;
    logic [2:0] xst;
    logic [7:0] zero_regs [6];
    logic [2:0] codes [3];
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;

    sbr_regs #(.NR_TIMEOUT(NR_T)) u_dut (.clock(clock), .rst_n(rst_n), .reset_line_n(reset_line_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .trigger_word(trigger_word), .trigger_mode(trigger_mode), .second_regulator_on(v2_on),
        .battery_switch_overtemp(sw_ot), .battery_low_condition(bat_low), .battery_high_condition(src[5] | bat_high),
        .high_temp(src[4]), .temp_prewarn(src[3]), .bus_fault(src[2]), .serial_error(src[1]),
        .wake_event(src[0]), .xcvr_overtemp(xcvr_ot), .xcvr_forced_term(xcvr_term), .irq_n(irq_n),
        .xcvr_state(xst), .chip_mode(mode), .watchdog_enabled(wd_en), .first_regulator_on(reg1_on),
        .second_regulator_allowed(reg2_ok));
    sbr_host u_host (.clock(clock), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            $display("[FAIL] %0t run did not finish in time", $time);
            end_of_test();
        end
    end

    task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, m, g, e);
        end
    endtask : chk

    task automatic rc(input logic [7:0] a, input logic [7:0] e, input string m);
        logic [7:0] d;
        u_host.rd(a, d);
        chk(d, e, m);
    endtask : rc

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask : cyc

    task automatic trig(input logic [1:0] m);
        @(negedge clock);
        trigger_mode = m;
        trigger_word = 1'b1;
        @(negedge clock);
        trigger_word = 1'b0;
        cyc(2);
    endtask : trig

    task automatic end_of_test();
        if (mismatches == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        {rst_n, trigger_word, trigger_mode, v2_on, sw_ot, bat_low, bat_high, xcvr_ot, xcvr_term, src} = '0;
        reset_line_n = 1'b1;
        zero_regs = '{ADDR_IRQ_ENABLE_A, ADDR_IRQ_ENABLE_B, ADDR_XCVR_CTRL, ADDR_IRQ_SOURCE_A, ADDR_IRQ_SOURCE_B,
            8'h30};
        codes = '{XCVR_RX_TX, XCVR_RX_ONLY, XCVR_TERM_BAT};
        cyc(3);
        rst_n = 1'b1;
        chk({6'h00, mode}, {6'h00, SBR_NORMAL_REQ}, "mode after power-on");
        trig(2'b01);
        chk({6'h00, mode}, {6'h00, SBR_NORMAL}, "normal mode");
        rc(ADDR_SUPPLY_STATUS, {4'h0, SUPPLY_POR}, "supply power-on");
        rc(ADDR_SUPPLY_STATUS, 8'h00, "supply after read");
        for (int i = 0; i < 6; i++) rc(zero_regs[i], 8'h00, "reset value");
        u_host.wr(ADDR_IRQ_ENABLE_A, 8'h0F);
        rc(ADDR_IRQ_ENABLE_A, 8'h0F, "mask a");
        u_host.wr(ADDR_IRQ_ENABLE_B, 8'h07);
        rc(ADDR_IRQ_ENABLE_B, 8'h07, "mask b");
        u_host.wr(ADDR_IRQ_ENABLE_A, 8'h00);
        u_host.wr(ADDR_IRQ_ENABLE_B, 8'h00);
        // Each of the six pin-mirrored interrupt sources in turn: copy, masked, enabled, untouched by its own access
        for (int i = 0; i < 6; i++) begin
            @(negedge clock);
            src = 6'h01 << i;
            cyc(8);
            rc(ADDR_IRQ_SOURCE_B, {5'h00, src[2:0]}, "source b");
            rc(ADDR_IRQ_SOURCE_A, {4'h0, src[5:3], 1'b0}, "source a");
            chk({7'h00, irq_n}, 8'h01, "irq while masked");
            u_host.wr(i < 3 ? ADDR_IRQ_ENABLE_B : ADDR_IRQ_ENABLE_A, i < 3 ? 8'h01 << i : 8'h02 << (i - 3));
            cyc(2);
            chk({7'h00, irq_n}, 8'h00, "irq when enabled");
            u_host.wr(i < 3 ? ADDR_IRQ_SOURCE_B : ADDR_IRQ_SOURCE_A, 8'h00);
            rc(ADDR_IRQ_SOURCE_B, {5'h00, src[2:0]}, "source b kept");
            rc(ADDR_IRQ_SOURCE_A, {4'h0, src[5:3], 1'b0}, "source a kept");
            src = '0;
            cyc(8);
            chk({7'h00, irq_n}, 8'h01, "irq after source gone");
            u_host.wr(i < 3 ? ADDR_IRQ_ENABLE_B : ADDR_IRQ_ENABLE_A, 8'h00);
        end
        @(negedge clock);
        bat_low = 1'b1;
        cyc(8);
        bat_low = 1'b0;
        cyc(8);
        rc(ADDR_IRQ_SOURCE_A, 8'h01, "latched battery low copy");
        u_host.wr(ADDR_IRQ_ENABLE_A, 8'h01);
        cyc(2);
        chk({7'h00, irq_n}, 8'h00, "irq from latched battery low");
        rc(ADDR_SUPPLY_STATUS, 8'h01, "battery low latched");
        rc(ADDR_SUPPLY_STATUS, 8'h00, "battery low cleared");
        cyc(2);
        chk({7'h00, irq_n}, 8'h01, "irq after battery low read");
        u_host.wr(ADDR_IRQ_ENABLE_A, 8'h00);
        {bat_high, v2_on, sw_ot} = 3'b111;
        cyc(8);
        sw_ot = 1'b0;
        cyc(8);
        rc(ADDR_SUPPLY_STATUS, 8'h0E, "high, regulator, overtemp");
        rc(ADDR_SUPPLY_STATUS, 8'h06, "overtemp cleared");
        v2_on = 1'b0;
        cyc(8);
        rc(ADDR_SUPPLY_STATUS, 8'h06, "regulator off latched");
        rc(ADDR_SUPPLY_STATUS, 8'h02, "regulator off");
        bat_high = 1'b0;
        cyc(8);
        rc(ADDR_SUPPLY_STATUS, 8'h00, "over-voltage gone");
        // Reset line clears masks and supply bits 3 and 2, keeps the transceiver setting
        u_host.wr(ADDR_XCVR_CTRL, {5'h00, XCVR_RX_TX});
        u_host.wr(ADDR_IRQ_ENABLE_A, 8'h0F);
        u_host.wr(ADDR_IRQ_ENABLE_B, 8'h07);
        {v2_on, sw_ot} = 2'b11;
        cyc(8);
        {v2_on, sw_ot} = 2'b00;
        cyc(8);
        reset_line_n = 1'b0;
        cyc(3);
        reset_line_n = 1'b1;
        cyc(2);
        for (int i = 0; i < 2; i++) rc(zero_regs[i], 8'h00, "mask after reset line");
        rc(ADDR_SUPPLY_STATUS, 8'h00, "supply after reset line");
        rc(ADDR_XCVR_CTRL, 8'h03, "transceiver kept");
        for (int i = 0; i < 3; i++) begin
            u_host.wr(ADDR_XCVR_CTRL, {5'h00, codes[i]});
            rc(ADDR_XCVR_CTRL, {5'h00, codes[i]}, "transceiver state");
            chk({5'h00, xst}, {5'h00, codes[i]}, "state pins");
        end
        u_host.wr(ADDR_XCVR_CTRL, {5'h00, XCVR_RX_TX});
        xcvr_ot = 1'b1;
        cyc(8);
        xcvr_ot = 1'b0;
        cyc(8);
        rc(ADDR_XCVR_CTRL, 8'h0B, "transceiver overtemp");
        rc(ADDR_XCVR_CTRL, 8'h03, "overtemp cleared by read");
        xcvr_term = 1'b1;
        cyc(8);
        chk({5'h00, xst}, 8'h00, "forced term");
        xcvr_term = 1'b0;
        cyc(8);
        rc(ADDR_XCVR_CTRL, 8'h00, "control bits cleared");
        u_host.wd_disable();
        cyc(2);
        chk({7'h00, wd_en}, 8'h01, "disable outside stand-by");
        trig(2'b11);
        chk({6'h00, mode}, {6'h00, SBR_STANDBY}, "stand-by mode");
        u_host.wd_disable();
        cyc(2);
        chk({7'h00, wd_en}, 8'h00, "watchdog off");
        chk({7'h00, reg2_ok}, 8'h00, "regulator two blocked");
        u_host.wr(ADDR_XCVR_CTRL, {5'h00, XCVR_RX_TX});
        cyc(2);
        chk({5'h00, xst}, 8'h00, "transceiver unusable");
        // Second power-on without a trigger word must end in sleep
        rst_n = 1'b0;
        cyc(3);
        rst_n = 1'b1;
        chk({7'h00, reg1_on}, 8'h01, "regulator one on");
        cyc(NR_T + 10);
        chk({6'h00, mode}, {6'h00, SBR_SLEEP}, "sleep after timeout");
        chk({7'h00, reg1_on}, 8'h00, "regulator one off");
        end_of_test();
    end
endmodule : sbr_regs_bench
